// [core/aux_ctl_cfg.svh]
// Register map, field positions and timing counts for the auxiliary control block
`ifndef AUX_CTL_CFG_SVH
`define AUX_CTL_CFG_SVH

// Word indices; byte address is four times the index
`define AUX_IDX_W 9
`define AUX_CTRL_IDX 9'h03f
`define AUX_SRST_IDX 9'h06c
`define AUX_STAT_IDX 9'h040

// Byte address bits that select a word
`define AUX_ADR_HI 10
`define AUX_ADR_LO 2

// Auxiliary control fields
`define AUX_SHORT_TICK 7
`define AUX_STALE_BYPASS 6
`define AUX_STALE_MASK 5
`define AUX_INPUT_HOLD 4
`define AUX_TOUT_CLEAR 3
`define AUX_DMA_RESYNC 1
`define AUX_CTRL_MASK 8'hfa

// Soft reset field
`define AUX_CHAN_RESET 0

// Status fields
`define AUX_ST_STALE 0
`define AUX_ST_TOUT 1
`define AUX_ST_FULL 2
`define AUX_ST_DMA_ACK 3

`define AUX_BYTE_LANE 0
`define AUX_ZERO_BYTE 8'h00
`define AUX_ZERO_WORD 32'h0000_0000

// Tick prescaler periods in system clocks, stale divider ratio
`define TICK_NORMAL_CLKS 8'hfa
`define TICK_SHORT_CLKS 8'h02
`define TICK_ONE 8'h01
`define TICK_ZERO 8'h00
`define STALE_DIV_LAST 4'h9
`define STALE_DIV_ZERO 4'h0
`define STALE_DIV_ONE 4'h1

`endif

// [core/aux_ctl_pkg.sv]
// State types for the auxiliary control and soft reset block
package aux_ctl_pkg;

  typedef struct packed {
    logic ack;
    logic [7:0] rdata;
    logic short_tick;
    logic stale_bypass;
    logic stale_mask;
    logic input_hold;
    logic tout_clear;
    logic dma_resync;
    logic chan_reset;
    logic chan_out;
    logic tout_latch;
    logic stale_status;
    logic single_char;
    logic dma_s1;
    logic dma_s2;
    logic dma_s3;
    logic discard;
  } main_state_s;

  typedef struct packed {
    logic [7:0] pre_cnt;
    logic [3:0] div_cnt;
    logic tick;
    logic step;
  } tick_state_s;

endpackage : aux_ctl_pkg

// [core/stale_tick.sv]
// Tick prescaler and divide-by-ten stage that pace the stale-data timer
`timescale 1ns/1ns
`include "aux_ctl_cfg.svh"

module stale_tick (
  input wire logic clk_i,
  input wire logic clr_i,
  input wire logic short_tick_i,
  input wire logic stale_bypass_i,
  output logic tick_o,
  output logic step_o
);

  aux_ctl_pkg::tick_state_s q;
  aux_ctl_pkg::tick_state_s d;
  logic [7:0] last;
  logic tick_now;

  always_comb begin
    d = q;
    last = short_tick_i ? (`TICK_SHORT_CLKS - `TICK_ONE) : (`TICK_NORMAL_CLKS - `TICK_ONE);
    tick_now = (q.pre_cnt >= last);
    d.pre_cnt = tick_now ? `TICK_ZERO : q.pre_cnt + `TICK_ONE;
    d.tick = tick_now;
    d.step = 1'b0;
    if (tick_now) begin
      if (stale_bypass_i) begin
        d.step = 1'b1;
      end else if (q.div_cnt == `STALE_DIV_LAST) begin
        d.step = 1'b1;
        d.div_cnt = `STALE_DIV_ZERO;
      end else begin
        d.div_cnt = q.div_cnt + `STALE_DIV_ONE;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (clr_i) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign tick_o = q.tick;
  assign step_o = q.step;

  sequence short_steady;
    short_tick_i [*3];
  endsequence

  a_short_tick_rate: assert property (@(posedge clk_i) disable iff (clr_i)
    (short_steady ##0 tick_o ##1 short_tick_i) |-> !tick_o ##1 tick_o)
    else $error("short tick not every second clock");

  a_step_on_tick: assert property (@(posedge clk_i) disable iff (clr_i)
    step_o |-> tick_o)
    else $error("stale step without a tick");

  a_fast_step_rate: assert property (@(posedge clk_i) disable iff (clr_i)
    ((short_tick_i && stale_bypass_i) [*4] ##0 step_o ##1 (short_tick_i && stale_bypass_i))
      |-> !step_o ##1 step_o)
    else $error("stale timer not stepping every second clock");

endmodule : stale_tick

// [core/aux_ctl.sv]
// Auxiliary control and channel soft reset registers on a classic Wishbone slave
// What this block does
// - Short tick: prescaler ticks every two clocks
// - Hardware reset clears short tick bit
// - Divide-by-ten stage, bypass steps every tick
// - Both bits set: step every second clock
// - Stale status is condition and not mask
// - Input hold refuses data, FIFO looks full
// - Hold withholds event 36, recovery discards byte
// - Timeout clear resets latch, set disables it
// - Clear set: no single character condition
// - Bits two and zero read zero
// - Resync bit adds clocked DMA acknowledge stage
// - Reset bit holds channel in reset
// - Channel reset touches only the channel
// - Channel reset clears FIFO control register
`timescale 1ns/1ns
`include "aux_ctl_cfg.svh"

module aux_ctl (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [10:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  input wire logic stale_cond_i,
  input wire logic single_char_cond_i,
  input wire logic timeout_event_i,
  output logic stale_status_o,
  output logic single_char_pending_o,
  output logic timeout_status_o,
  output logic stale_tick_o,
  output logic stale_step_o,
  input wire logic port_wr_valid_i,
  input wire logic fifo_ready_i,
  input wire logic fifo_full_i,
  output logic port_wr_ready_o,
  output logic fifo_wr_valid_o,
  output logic fifo_full_o,
  input wire logic ecp_ev36_req_i,
  input wire logic ecp_recover_i,
  output logic ecp_ev36_o,
  output logic ecp_discard_o,
  input wire logic dma_acknowledge_n_i,
  output logic dma_ack_n_o,
  output logic chan_reset_o,
  output logic fifo_ctl_clear_o
);

  aux_ctl_pkg::main_state_s q;
  aux_ctl_pkg::main_state_s d;
  logic [`AUX_IDX_W-1:0] idx;
  logic req;
  logic wr;
  logic [7:0] ctrl_rd;
  logic [7:0] srst_rd;
  logic [7:0] stat_rd;
  logic [7:0] rd_mux;
  logic timer_clr;

  assign idx = adr_i[`AUX_ADR_HI:`AUX_ADR_LO];
  assign req = cyc_i && stb_i;
  // Write lands at the edge where the master sees ack
  assign wr = req && we_i && q.ack && sel_i[`AUX_BYTE_LANE];

  always_comb begin
    ctrl_rd = `AUX_ZERO_BYTE;
    ctrl_rd[`AUX_SHORT_TICK] = q.short_tick;
    ctrl_rd[`AUX_STALE_BYPASS] = q.stale_bypass;
    ctrl_rd[`AUX_STALE_MASK] = q.stale_mask;
    ctrl_rd[`AUX_INPUT_HOLD] = q.input_hold;
    ctrl_rd[`AUX_TOUT_CLEAR] = q.tout_clear;
    ctrl_rd[`AUX_DMA_RESYNC] = q.dma_resync;
    srst_rd = `AUX_ZERO_BYTE;
    srst_rd[`AUX_CHAN_RESET] = q.chan_reset;
    stat_rd = `AUX_ZERO_BYTE;
    stat_rd[`AUX_ST_STALE] = q.stale_status;
    stat_rd[`AUX_ST_TOUT] = q.tout_latch;
    stat_rd[`AUX_ST_FULL] = fifo_full_o;
    stat_rd[`AUX_ST_DMA_ACK] = dma_ack_n_o;
    unique case (idx)
      `AUX_CTRL_IDX: rd_mux = ctrl_rd;
      `AUX_SRST_IDX: rd_mux = srst_rd;
      `AUX_STAT_IDX: rd_mux = stat_rd;
      default: rd_mux = `AUX_ZERO_BYTE;
    endcase
  end

  always_comb begin
    d = q;
    // Single-cycle answer; unmapped words ack with zero data
    d.ack = req && !q.ack;
    if (req && !q.ack) begin
      d.rdata = we_i ? `AUX_ZERO_BYTE : rd_mux;
    end
    if (wr && idx == `AUX_CTRL_IDX) begin
      d.short_tick = dat_i[`AUX_SHORT_TICK];
      d.stale_bypass = dat_i[`AUX_STALE_BYPASS];
      d.stale_mask = dat_i[`AUX_STALE_MASK];
      d.input_hold = dat_i[`AUX_INPUT_HOLD];
      d.tout_clear = dat_i[`AUX_TOUT_CLEAR];
      d.dma_resync = dat_i[`AUX_DMA_RESYNC];
    end
    // Upper bits of the reset word are dropped, only bit zero is stored
    if (wr && idx == `AUX_SRST_IDX) begin
      d.chan_reset = dat_i[`AUX_CHAN_RESET];
    end
    // Channel reset line follows the bit; aux bits and bus stay untouched
    d.chan_out = d.chan_reset;
    // Rising clear empties the latch; while set the latch is held clear,
    // so the falling write changes nothing
    if (q.tout_clear || q.chan_reset) begin
      d.tout_latch = 1'b0;
    end else if (timeout_event_i) begin
      d.tout_latch = 1'b1;
    end
    d.stale_status = stale_cond_i && !q.stale_mask;
    d.single_char = single_char_cond_i && !q.stale_mask && !q.tout_clear;
    if (q.chan_reset) begin
      d.stale_status = 1'b0;
      d.single_char = 1'b0;
    end
    d.dma_s1 = dma_acknowledge_n_i;
    d.dma_s2 = q.dma_s1;
    d.dma_s3 = q.dma_s2;
    // Host recovery from the stall drops the byte in flight
    d.discard = ecp_recover_i && q.input_hold && !q.chan_reset;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      q <= '0;
      q.chan_out <= 1'b1;
      q.dma_s1 <= 1'b1;
      q.dma_s2 <= 1'b1;
      q.dma_s3 <= 1'b1;
    end else begin
      q <= d;
    end
  end

  assign timer_clr = rst_i || q.chan_reset;

  stale_tick u_stale_tick (
    .clk_i(clk_i),
    .clr_i(timer_clr),
    .short_tick_i(q.short_tick),
    .stale_bypass_i(q.stale_bypass),
    .tick_o(stale_tick_o),
    .step_o(stale_step_o)
  );

  assign dat_o = {24'h00_0000, q.rdata};
  assign ack_o = q.ack;
  assign stale_status_o = q.stale_status;
  assign single_char_pending_o = q.single_char;
  assign timeout_status_o = q.tout_latch;
  // Hold makes the FIFO refuse the port and look full, so the port goes busy
  assign port_wr_ready_o = fifo_ready_i && !q.input_hold && !q.chan_reset;
  assign fifo_wr_valid_o = port_wr_valid_i && port_wr_ready_o;
  assign fifo_full_o = fifo_full_i || q.input_hold;
  assign ecp_ev36_o = ecp_ev36_req_i && !q.input_hold && !q.chan_reset;
  assign ecp_discard_o = q.discard;
  assign dma_ack_n_o = q.dma_resync ? q.dma_s3 : q.dma_s2;
  assign chan_reset_o = q.chan_out;
  assign fifo_ctl_clear_o = q.chan_out;

  sequence resync_held;
    q.dma_resync [*4];
  endsequence

  sequence clear_held;
    q.tout_clear [*2];
  endsequence

  a_ack_single: assert property (@(posedge clk_i) disable iff (rst_i)
    (req && !ack_o) |=> ack_o ##1 !ack_o)
    else $error("ack not a single cycle after request");

  a_reserved_zero: assert property (@(posedge clk_i) disable iff (rst_i)
    (req && !we_i && !ack_o && idx == `AUX_CTRL_IDX) |=> (dat_o[2] == 1'b0 && dat_o[0] == 1'b0))
    else $error("reserved control bits read nonzero");

  a_reset_clears: assert property (@(posedge clk_i)
    $fell(rst_i) |-> (!q.short_tick && !q.chan_reset && ctrl_rd == `AUX_ZERO_BYTE))
    else $error("registers not zero after reset");

  a_reset_readback: assert property (@(posedge clk_i)
    ($fell(rst_i) ##1 (req && !we_i && (idx == `AUX_CTRL_IDX || idx == `AUX_SRST_IDX)))
      |=> dat_o == `AUX_ZERO_WORD)
    else $error("soft reset register not zero after reset");

  a_stale_masking: assert property (@(posedge clk_i) disable iff (rst_i)
    ($past(q.stale_mask) && !$past(rst_i)) |-> !stale_status_o)
    else $error("stale status not masked");

  a_hold_refuses: assert property (@(posedge clk_i) disable iff (rst_i)
    q.input_hold |-> (!port_wr_ready_o && !fifo_wr_valid_o && fifo_full_o))
    else $error("held FIFO accepted data or looked not full");

  a_ev36_withheld: assert property (@(posedge clk_i) disable iff (rst_i)
    (q.input_hold && ecp_ev36_req_i) |-> !ecp_ev36_o ##1 (ecp_discard_o == $past(ecp_recover_i && !q.chan_reset)))
    else $error("event 36 given or byte kept while held");

  a_tout_disabled: assert property (@(posedge clk_i) disable iff (rst_i)
    clear_held |-> !timeout_status_o)
    else $error("timeout status active while clear set");

  a_no_one_char: assert property (@(posedge clk_i) disable iff (rst_i)
    clear_held |-> !single_char_pending_o)
    else $error("single character raised while clear set");

  a_clear_once: assert property (@(posedge clk_i) disable iff (rst_i)
    ($fell(q.tout_clear) && !q.chan_reset && !$past(timeout_event_i)) |-> !timeout_status_o)
    else $error("timeout latch not cleared by toggle");

  a_dma_resync: assert property (@(posedge clk_i) disable iff (rst_i)
    resync_held |-> dma_ack_n_o == $past(dma_acknowledge_n_i, 3))
    else $error("resynced acknowledge not three clocks late");

  a_chan_reset: assert property (@(posedge clk_i) disable iff (rst_i)
    q.chan_reset |-> (chan_reset_o && fifo_ctl_clear_o && !port_wr_ready_o) ##1 !stale_status_o)
    else $error("channel not held in reset");

  a_chan_only: assert property (@(posedge clk_i) disable iff (rst_i)
    (q.chan_reset && !wr) |=> $stable(ctrl_rd))
    else $error("channel reset disturbed control register");

  sequence ctrl_read;
    req && !we_i && !ack_o && idx == `AUX_CTRL_IDX;
  endsequence

  sequence srst_read;
    req && !we_i && !ack_o && idx == `AUX_SRST_IDX;
  endsequence

  a_ctrl_readback: assert property (@(posedge clk_i) disable iff (rst_i)
    ctrl_read |=> 8'(dat_o) == $past(ctrl_rd))
    else $error("control read data not the stored bits");

  a_srst_readback: assert property (@(posedge clk_i) disable iff (rst_i)
    srst_read |=> 8'(dat_o) == $past(srst_rd))
    else $error("soft reset read data not the stored bit");

  a_ctrl_write: assert property (@(posedge clk_i) disable iff (rst_i)
    (wr && idx == `AUX_CTRL_IDX) |=> ctrl_rd == (8'($past(dat_i)) & `AUX_CTRL_MASK))
    else $error("control write not stored");

  a_srst_write: assert property (@(posedge clk_i) disable iff (rst_i)
    (wr && idx == `AUX_SRST_IDX) |=> q.chan_reset == $past(dat_i[`AUX_CHAN_RESET]))
    else $error("channel reset bit not stored");

  a_stale_follow: assert property (@(posedge clk_i) disable iff (rst_i)
    (!q.stale_mask && !q.chan_reset) |=> stale_status_o == $past(stale_cond_i))
    else $error("stale status does not follow the condition");

  a_one_char_follow: assert property (@(posedge clk_i) disable iff (rst_i)
    (!q.stale_mask && !q.tout_clear && !q.chan_reset)
      |=> single_char_pending_o == $past(single_char_cond_i))
    else $error("single character does not follow the condition");

  a_one_char_masked: assert property (@(posedge clk_i) disable iff (rst_i)
    q.stale_mask |=> !single_char_pending_o)
    else $error("single character raised while masked");

  a_full_follow: assert property (@(posedge clk_i) disable iff (rst_i)
    !q.input_hold |-> fifo_full_o == fifo_full_i)
    else $error("full flag wrong without hold");

  a_ready_follow: assert property (@(posedge clk_i) disable iff (rst_i)
    (!q.input_hold && !q.chan_reset) |-> port_wr_ready_o == fifo_ready_i)
    else $error("port ready wrong without hold");

  a_ev36_pass: assert property (@(posedge clk_i) disable iff (rst_i)
    (!q.input_hold && !q.chan_reset) |-> ecp_ev36_o == ecp_ev36_req_i)
    else $error("event 36 blocked without hold");

  a_discard_free: assert property (@(posedge clk_i) disable iff (rst_i)
    !q.input_hold |=> !ecp_discard_o)
    else $error("byte discarded without hold");

  a_latch_set: assert property (@(posedge clk_i) disable iff (rst_i)
    (timeout_event_i && !q.tout_clear && !q.chan_reset) |=> timeout_status_o)
    else $error("timeout event not latched");

  a_latch_hold: assert property (@(posedge clk_i) disable iff (rst_i)
    (timeout_status_o && !q.tout_clear && !q.chan_reset) |=> timeout_status_o)
    else $error("timeout status lost without clear");

  a_dma_direct: assert property (@(posedge clk_i) disable iff (rst_i)
    (!q.dma_resync && !$past(rst_i) && !$past(rst_i, 2))
      |-> dma_ack_n_o == $past(dma_acknowledge_n_i, 2))
    else $error("acknowledge not two clocks late");

  a_chan_release: assert property (@(posedge clk_i) disable iff (rst_i)
    (!q.chan_reset && !$past(rst_i)) |-> (!chan_reset_o && !fifo_ctl_clear_o))
    else $error("channel reset output without the bit");

  a_timer_clear: assert property (@(posedge clk_i) disable iff (rst_i)
    q.chan_reset |=> (!stale_tick_o && !stale_step_o))
    else $error("stale timer running in channel reset");

  a_hw_reset_out: assert property (@(posedge clk_i)
    rst_i |=> (chan_reset_o && fifo_ctl_clear_o && !ack_o))
    else $error("hardware reset not driven to the channel");

endmodule : aux_ctl

// [bench/channel_model.sv]
// Stand-in for the parallel channel: random condition and handshake levels
`timescale 1ns/1ns

module channel_model (
  input wire logic clk_i,
  output logic stale_o,
  output logic single_o,
  output logic wr_valid_o,
  output logic ready_o,
  output logic full_o,
  output logic ev36_req_o,
  output logic recover_o
);
  initial begin
    {stale_o, single_o, wr_valid_o, ready_o, full_o, ev36_req_o, recover_o} = 7'h00;
  end

  // New levels just after each rising edge
  always @(posedge clk_i) begin
    {stale_o, single_o, wr_valid_o, ready_o, full_o, ev36_req_o, recover_o} <= 7'($urandom);
  end
endmodule : channel_model

// [bench/parallel_aux_control_reset_bench.sv]
// Self-checking bench for the auxiliary control and channel soft reset block
`timescale 1ns/1ns

module parallel_aux_control_reset_bench;
  logic clk_i = 1'b0, rst_i = 1'b1, cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0;
  logic tev = 1'b0, pin_n = 1'b1, ack_o, cr = 1'b0, ps, pc, prc, have;
  logic [10:0] adr_i = 11'h000;
  logic [31:0] dat_i = 32'h0000_0000, dat_o;
  logic [7:0] ctl = 8'h00, rd;
  logic st_o, sc_o, to_o, tk_o, sp_o, pr_o, fw_o, ff_o, e36_o, dis_o, dn_o, cr_o, fc_o;
  logic stl, sgl, pv, frdy, ffull, ereq, erec;
  logic [7:0] tc[4] = '{8'h00, 8'h80, 8'h40, 8'hc0};
  int te[4] = '{250, 2, 250, 2};
  int se[4] = '{2500, 20, 250, 2};
  int miscompares = 0, checks = 0, n;

  always #50 clk_i = ~clk_i;

  aux_ctl aux_ctl_inst (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
    .adr_i(adr_i), .sel_i(4'hf), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
    .stale_cond_i(stl), .single_char_cond_i(sgl), .timeout_event_i(tev),
    .stale_status_o(st_o), .single_char_pending_o(sc_o), .timeout_status_o(to_o),
    .stale_tick_o(tk_o), .stale_step_o(sp_o), .port_wr_valid_i(pv), .fifo_ready_i(frdy),
    .fifo_full_i(ffull), .port_wr_ready_o(pr_o), .fifo_wr_valid_o(fw_o), .fifo_full_o(ff_o),
    .ecp_ev36_req_i(ereq), .ecp_recover_i(erec), .ecp_ev36_o(e36_o), .ecp_discard_o(dis_o),
    .dma_acknowledge_n_i(pin_n), .dma_ack_n_o(dn_o), .chan_reset_o(cr_o),
    .fifo_ctl_clear_o(fc_o));

  channel_model channel_model_inst (.clk_i(clk_i), .stale_o(stl), .single_o(sgl),
    .wr_valid_o(pv), .ready_o(frdy), .full_o(ffull), .ev36_req_o(ereq), .recover_o(erec));

  task check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check

  task finish_test;
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : finish_test

  // Classic single cycle; entered just after a rising edge, or just after a falling edge when it follows sweep
  task automatic wb(input logic w, input logic [10:0] a, input logic [7:0] d);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    adr_i <= a;
    dat_i <= {24'h000000, d};
    // No limit here; the watchdog ends a hung bus
    do begin
      @(posedge clk_i);
    end while (ack_o !== 1'b1);
    rd = dat_o[7:0];
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    we_i <= 1'b0;
    @(posedge clk_i);
  endtask : wb

  task automatic sweep(input int cnt);
    have = 1'b0;
    repeat (cnt) begin
      @(negedge clk_i);
      check("port_wr_ready", pr_o, frdy & ~ctl[4] & ~cr);
      check("fifo_wr_valid", fw_o, pv & frdy & ~ctl[4] & ~cr);
      check("fifo_full", ff_o, ffull | ctl[4]);
      check("ev36", e36_o, ereq & ~ctl[4] & ~cr);
      check("chan_reset", cr_o, cr);
      check("fifo_ctl_clear", fc_o, cr);
      if (have) begin
        check("stale", st_o, ps & ~ctl[5] & ~cr);
        if (!cr) begin
          check("single", sc_o, pc & ~ctl[5] & ~ctl[3]);
          check("discard", dis_o, prc & ctl[4]);
        end
      end
      {ps, pc, prc, have} = {stl, sgl, erec, 1'b1};
    end
  endtask : sweep

  task automatic pulse(input logic exp);
    tev <= 1'b1;
    @(posedge clk_i);
    tev <= 1'b0;
    repeat (2) @(posedge clk_i);
    check("timeout_status", to_o, exp);
  endtask : pulse

  task automatic period(input logic st);
    repeat (2) begin
      n = 0;
      do begin
        @(posedge clk_i);
        n++;
      end while ((st ? sp_o : tk_o) !== 1'b1 && n < 3000);
    end
  endtask : period

  initial begin
    void'($urandom(36));
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    wb(1'b0, 11'h0fc, 8'h00);
    check("ctl_reset", rd, 8'h00);
    wb(1'b0, 11'h1b0, 8'h00);
    check("srst_reset", rd, 8'h00);
    wb(1'b0, 11'h004, 8'h00);
    check("unmapped", rd, 8'h00);
    wb(1'b1, 11'h0fc, 8'hff);
    wb(1'b0, 11'h0fc, 8'h00);
    check("ctl_reserved", rd, 8'hfa);
    rst_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    wb(1'b0, 11'h0fc, 8'h00);
    check("ctl_hw_reset", rd, 8'h00);
    for (int i = 0; i < 8; i++) begin
      ctl = 8'(i << 3);
      wb(1'b1, 11'h0fc, ctl);
      sweep(20);
    end
    ctl = 8'h10;
    wb(1'b1, 11'h0fc, ctl);
    wb(1'b1, 11'h1b0, 8'h01);
    cr = 1'b1;
    sweep(10);
    wb(1'b0, 11'h0fc, 8'h00);
    check("ctl_kept", rd, 8'h10);
    wb(1'b1, 11'h1b0, 8'h00);
    cr = 1'b0;
    sweep(10);
    ctl = 8'h00;
    wb(1'b1, 11'h0fc, ctl);
    pulse(1'b1);
    ctl = 8'h08;
    wb(1'b1, 11'h0fc, ctl);
    @(posedge clk_i);
    check("tout_cleared", to_o, 1'b0);
    pulse(1'b0);
    ctl = 8'h00;
    wb(1'b1, 11'h0fc, ctl);
    @(posedge clk_i);
    check("tout_once", to_o, 1'b0);
    pulse(1'b1);
    // Mask and hold set: stale 0, latch 1, full 1, acknowledge idle high
    wb(1'b1, 11'h0fc, 8'h30);
    wb(1'b0, 11'h100, 8'h00);
    check("status", rd, 8'h0e);
    for (int i = 0; i < 4; i++) begin
      wb(1'b1, 11'h0fc, tc[i]);
      period(1'b0);
      check("tick_period", n, te[i]);
      period(1'b1);
      check("step_period", n, se[i]);
    end
    for (int i = 0; i < 2; i++) begin
      wb(1'b1, 11'h0fc, i ? 8'h02 : 8'h00);
      pin_n <= 1'b0;
      n = 0;
      do begin
        @(posedge clk_i);
        n++;
      end while (dn_o !== 1'b0 && n < 10);
      check("dma_delay", n, 3 + i);
      pin_n <= 1'b1;
      repeat (5) @(posedge clk_i);
    end
    finish_test();
  end

  initial begin
    repeat (40000) @(posedge clk_i);
    miscompares++;
    finish_test();
  end
endmodule : parallel_aux_control_reset_bench
